// File: src/trig_qualifier.sv
// Purpose: Decides when sample collection starts and tracks peaks afterwards.
// Assumes: Setup ports are steady when arm_start pulses; samples on sys_clk.
// Notes: Setup is captured on arm_start; pins pass two flip-flops first.
`timescale 1ns/10ps

// How it works
// - Software source is the default selection
// - Software source triggers right after arm
// - Command source triggers on word-serial command
// - External source needs a real programmed edge
// - Strobe chosen backplane output line on trigger
// - Above or below signed level triggers
// - Out-of-range level flagged at arm time
// - Slope triggers one sample after crossing
// - Levels rounded, compared on top eight bits
// - Track maximum and minimum after trigger
// - Max and min readable by readout command
// - No tracking in record mode
// - No tracking while external gate active
// - Full-scale preload without threshold source
// - Combine two sources by OR or AND
// - AND latches first satisfied condition
// - AND enables level detector after other
module trig_qualifier
	import trig_qual_pkg::*;
(
	input wire logic sys_clk, // Sample clock
	input wire logic rst_b, // Async reset, active low
	input wire logic arm_start, // Arm/start command pulse
	input wire logic cmd_trig, // Word-serial trigger command pulse
	input wire trig_src_t src_a, // First source
	input wire trig_src_t src_b, // Second source
	input wire logic use_b, // Second source given
	input wire logic and_mode, // Combine with AND, else OR
	input wire logic [LEVEL_IN_W-1:0] level_a, // First level, signed counts
	input wire logic [LEVEL_IN_W-1:0] level_b, // Second level, signed counts
	input wire logic [LINE_W-1:0] backplane_input_line_select, // Input line
	input wire logic bp_rising, // Backplane input edge is rising
	input wire logic out_en, // Output strobe wanted
	input wire logic [LINE_W-1:0] out_line, // Output strobe line
	input wire logic record_mode, // Record mode active
	input wire logic readout_req, // Comparator readout command pulse
	input wire logic [SAMPLE_W-1:0] sample, // Digitized sample
	input wire logic ext_trig_pin, // External TTL trigger pin
	input wire logic ext_gate_pin, // External gate pin, active high
	input wire logic [LINES-1:0] bp_ttl_in, // Backplane trigger line levels
	output logic collecting, // Triggered, collection running
	output logic trig_pulse, // One-cycle trigger event
	output logic arm_error, // Level out of range at last arm
	output logic [LINES-1:0] bp_ttl_o, // Backplane drive value, low
	output logic [LINES-1:0] bp_ttl_oe, // Backplane drive enable
	output logic [SAMPLE_W-1:0] max_val, // Running maximum
	output logic [SAMPLE_W-1:0] min_val, // Running minimum
	output logic [SAMPLE_W-1:0] readout_max, // Maximum at readout
	output logic [SAMPLE_W-1:0] readout_min, // Minimum at readout
	output logic readout_valid // Readout words valid pulse
);

	qual_state_t state;
	qual_state_t next_state;
	trig_src_t cfg_a;
	trig_src_t cfg_b;
	trig_src_t next_cfg_a;
	trig_src_t next_cfg_b;
	logic cfg_and;
	logic next_cfg_and;
	logic cfg_out;
	logic next_cfg_out;
	logic [LINE_W-1:0] cfg_out_line;
	logic [LINE_W-1:0] next_cfg_out_line;
	logic [LINE_W-1:0] cfg_in_line;
	logic [LINE_W-1:0] next_cfg_in_line;
	logic cfg_rising;
	logic next_cfg_rising;
	logic [LEVEL_W-1:0] lvl_a;
	logic [LEVEL_W-1:0] lvl_b;
	logic [LEVEL_W-1:0] next_lvl_a;
	logic [LEVEL_W-1:0] next_lvl_b;
	logic latch_a;
	logic latch_b;
	logic next_latch_a;
	logic next_latch_b;
	logic next_collecting;
	logic next_trig_pulse;
	logic next_arm_error;
	logic [CNT_W-1:0] strobe_cnt;
	logic [CNT_W-1:0] next_strobe_cnt;
	logic [LINES-1:0] next_bp_oe;
	logic [LEVEL_W-1:0] prev_hi;
	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic [PIN_W-1:0] pin_prev;
	logic [LEVEL_IN_W-1:0] sum_a;
	logic [LEVEL_IN_W-1:0] sum_b;
	logic level_ok;
	logic hit_a;
	logic hit_b;
	logic en_a;
	logic en_b;
	logic fire;
	logic any_level;
	logic load_peaks;
	logic track;
	logic [SAMPLE_W-1:0] pre_max;
	logic [SAMPLE_W-1:0] pre_min;
	logic [SAMPLE_W-1:0] next_ro_max;
	logic [SAMPLE_W-1:0] next_ro_min;

	// Pin synchroniser: the first stage feeds only the second
	// Backplane bits reset to their pulled-up idle level, so no false edge follows reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_meta <= {{(PIN_W-LINES){1'b0}}, ~LINES_OFF};
			pin_sync <= {{(PIN_W-LINES){1'b0}}, ~LINES_OFF};
			pin_prev <= {{(PIN_W-LINES){1'b0}}, ~LINES_OFF};
			prev_hi <= '0;
		end else begin
			pin_meta <= {ext_trig_pin, ext_gate_pin, bp_ttl_in};
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			prev_hi <= sample[SAMPLE_W-1 -: LEVEL_W];
		end
	end

	// Level rounding and range check on the programmed setup
	assign sum_a = level_a + ROUND_BIAS;
	assign sum_b = level_b + ROUND_BIAS;
	assign level_ok = (!is_level(src_a) ||
		sum_a[LEVEL_IN_W-1:LEVEL_SIGN] == {(LEVEL_IN_W-LEVEL_SIGN){sum_a[LEVEL_SIGN]}}) &&
		(!use_b || !is_level(src_b) ||
		sum_b[LEVEL_IN_W-1:LEVEL_SIGN] == {(LEVEL_IN_W-LEVEL_SIGN){sum_b[LEVEL_SIGN]}});

	// In AND mode a level or slope detector waits for the other condition when that one is not a level source
	assign en_a = !cfg_and || !is_level(cfg_a) || is_level(cfg_b) || latch_b;
	assign en_b = !cfg_and || !is_level(cfg_b) || is_level(cfg_a) || latch_a;

	cond_detect u_cond_a (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.src(cfg_a),
		.enable(en_a && state == armed_st),
		.level(lvl_a),
		.sample_hi(sample[SAMPLE_W-1 -: LEVEL_W]),
		.prev_hi(prev_hi),
		.cmd_hit(cmd_trig),
		.ext_now(pin_sync[PIN_EXT]),
		.ext_prev(pin_prev[PIN_EXT]),
		.bp_now(pin_sync[LINES-1:0]),
		.bp_prev(pin_prev[LINES-1:0]),
		.bp_sel(cfg_in_line),
		.bp_rising(cfg_rising),
		.hit(hit_a)
	);

	cond_detect u_cond_b (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.src(cfg_b),
		.enable(en_b && state == armed_st),
		.level(lvl_b),
		.sample_hi(sample[SAMPLE_W-1 -: LEVEL_W]),
		.prev_hi(prev_hi),
		.cmd_hit(cmd_trig),
		.ext_now(pin_sync[PIN_EXT]),
		.ext_prev(pin_prev[PIN_EXT]),
		.bp_now(pin_sync[LINES-1:0]),
		.bp_prev(pin_prev[LINES-1:0]),
		.bp_sel(cfg_in_line),
		.bp_rising(cfg_rising),
		.hit(hit_b)
	);

	// Combination: a single source is ORed with itself
	assign fire = cfg_and ? ((latch_a || hit_a) && (latch_b || hit_b)) :
		(hit_a || hit_b);

	// Trigger state, setup capture and AND latches
	always_comb begin
		next_state = state;
		next_cfg_a = cfg_a;
		next_cfg_b = cfg_b;
		next_cfg_and = cfg_and;
		next_cfg_out = cfg_out;
		next_cfg_out_line = cfg_out_line;
		next_cfg_in_line = cfg_in_line;
		next_cfg_rising = cfg_rising;
		next_lvl_a = lvl_a;
		next_lvl_b = lvl_b;
		next_latch_a = latch_a;
		next_latch_b = latch_b;
		next_arm_error = arm_error;
		next_trig_pulse = 1'b0;
		if (arm_start) begin
			next_cfg_a = src_a;
			next_cfg_b = use_b ? src_b : src_a;
			next_cfg_and = use_b && and_mode;
			next_cfg_out = out_en;
			next_cfg_out_line = out_line;
			next_cfg_in_line = backplane_input_line_select;
			next_cfg_rising = bp_rising;
			next_lvl_a = sum_a[LEVEL_LSB +: LEVEL_W];
			next_lvl_b = use_b ? sum_b[LEVEL_LSB +: LEVEL_W] : sum_a[LEVEL_LSB +: LEVEL_W];
			next_latch_a = 1'b0;
			next_latch_b = 1'b0;
			next_arm_error = !level_ok;
			next_state = level_ok ? armed_st : idle_st;
		end else begin
			case (state)
				idle_st: begin
					next_state = idle_st;
				end
				armed_st: begin
					next_latch_a = latch_a || hit_a;
					next_latch_b = latch_b || hit_b;
					if (fire) begin
						next_trig_pulse = 1'b1;
						next_state = collect_st;
					end
				end
				collect_st: begin
					next_state = collect_st;
				end
				default: begin
					next_state = idle_st;
				end
			endcase
		end
	end

	assign next_collecting = (next_state == collect_st);

	// Output strobe on the chosen line, open-drain so only driven low
	always_comb begin
		next_strobe_cnt = strobe_cnt;
		next_bp_oe = bp_ttl_oe;
		if (next_trig_pulse && cfg_out) begin
			next_strobe_cnt = STROBE_LOAD;
			next_bp_oe = LINE_ONE << cfg_out_line;
		end else if (strobe_cnt > CNT_ONE) begin
			next_strobe_cnt = strobe_cnt - CNT_ONE;
		end else begin
			next_strobe_cnt = CNT_ZERO;
			next_bp_oe = LINES_OFF;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= idle_st;
			cfg_a <= software_source_mode;
			cfg_b <= software_source_mode;
			cfg_and <= 1'b0;
			cfg_out <= 1'b0;
			cfg_out_line <= '0;
			cfg_in_line <= '0;
			cfg_rising <= 1'b0;
			lvl_a <= '0;
			lvl_b <= '0;
			latch_a <= 1'b0;
			latch_b <= 1'b0;
			arm_error <= 1'b0;
			trig_pulse <= 1'b0;
			collecting <= 1'b0;
			strobe_cnt <= CNT_ZERO;
			bp_ttl_oe <= LINES_OFF;
			bp_ttl_o <= LINES_OFF;
		end else begin
			state <= next_state;
			cfg_a <= next_cfg_a;
			cfg_b <= next_cfg_b;
			cfg_and <= next_cfg_and;
			cfg_out <= next_cfg_out;
			cfg_out_line <= next_cfg_out_line;
			cfg_in_line <= next_cfg_in_line;
			cfg_rising <= next_cfg_rising;
			lvl_a <= next_lvl_a;
			lvl_b <= next_lvl_b;
			latch_a <= next_latch_a;
			latch_b <= next_latch_b;
			arm_error <= next_arm_error;
			trig_pulse <= next_trig_pulse;
			collecting <= next_collecting;
			strobe_cnt <= next_strobe_cnt;
			bp_ttl_oe <= next_bp_oe;
			bp_ttl_o <= LINES_OFF;
		end
	end

	// Comparator preload on arm and tracking after the trigger
	assign any_level = is_level(src_a) || (use_b && is_level(src_b));
	assign load_peaks = arm_start && level_ok;
	assign pre_max = is_level(src_a) ? {sum_a[LEVEL_LSB +: LEVEL_W], LEVEL_PAD} :
		(any_level ? {sum_b[LEVEL_LSB +: LEVEL_W], LEVEL_PAD} : NEG_FULL_SCALE);
	assign pre_min = (use_b && is_level(src_b)) ? {sum_b[LEVEL_LSB +: LEVEL_W], LEVEL_PAD} :
		(any_level ? {sum_a[LEVEL_LSB +: LEVEL_W], LEVEL_PAD} : POS_FULL_SCALE);
	assign track = collecting && !record_mode && !pin_sync[PIN_GATE];

	peak_track u_peaks (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.load(load_peaks),
		.load_max(pre_max),
		.load_min(pre_min),
		.update(track),
		.sample(sample),
		.max_val(max_val),
		.min_val(min_val)
	);

	// Readout command snapshots both comparators
	always_comb begin
		next_ro_max = readout_max;
		next_ro_min = readout_min;
		if (readout_req) begin
			next_ro_max = max_val;
			next_ro_min = min_val;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			readout_max <= NEG_FULL_SCALE;
			readout_min <= POS_FULL_SCALE;
			readout_valid <= 1'b0;
		end else begin
			readout_max <= next_ro_max;
			readout_min <= next_ro_min;
			readout_valid <= readout_req;
		end
	end

	// Checks on the trigger path and the peak comparators
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_strobe_held;
		(bp_ttl_oe == (LINE_ONE << cfg_out_line)) [*8];
	endsequence

	property p_soft;
		state == armed_st && cfg_a == software_source_mode && cfg_b == cfg_a && !arm_start
			|=> trig_pulse && collecting;
	endproperty
	a_soft: assert property (p_soft) else $error("software source did not trigger");

	property p_cmd;
		state == armed_st && cfg_a == command_source_mode && cfg_b == cfg_a &&
			cmd_trig && !arm_start |=> trig_pulse;
	endproperty
	a_cmd: assert property (p_cmd) else $error("command trigger missed");

	property p_ext_edge;
		trig_pulse && cfg_a == ext_rise_mode && cfg_b == cfg_a
			|-> $past(pin_sync[PIN_EXT]) && !$past(pin_prev[PIN_EXT]);
	endproperty
	a_ext_edge: assert property (p_ext_edge) else $error("external trigger without edge");

	property p_strobe;
		trig_pulse && cfg_out |-> s_strobe_held;
	endproperty
	a_strobe: assert property (p_strobe) else $error("output strobe not held");

	property p_above;
		state == armed_st && cfg_a == above_level_mode && cfg_b == cfg_a && !arm_start &&
			$signed(sample[SAMPLE_W-1 -: LEVEL_W]) > $signed(lvl_a) |=> trig_pulse;
	endproperty
	a_above: assert property (p_above) else $error("above level missed");

	property p_range;
		arm_start && !level_ok |=> arm_error && state == idle_st;
	endproperty
	a_range: assert property (p_range) else $error("range error not flagged");

	sequence s_rise_cross;
		state == armed_st && !arm_start && cfg_a == slope_rise_mode && cfg_b == cfg_a &&
			$signed(prev_hi) <= $signed(lvl_a) &&
			$signed(sample[SAMPLE_W-1 -: LEVEL_W]) > $signed(lvl_a);
	endsequence

	property p_slope;
		s_rise_cross ##1 !arm_start |=> trig_pulse;
	endproperty
	a_slope: assert property (p_slope) else $error("slope trigger timing wrong");

	property p_max;
		track && !arm_start && $signed(sample) > $signed(max_val) |=> max_val == $past(sample);
	endproperty
	a_max: assert property (p_max) else $error("maximum not tracked");

	property p_record;
		collecting && record_mode && !arm_start |=> $stable(max_val) && $stable(min_val);
	endproperty
	a_record: assert property (p_record) else $error("tracking in record mode");

	property p_and;
		state == armed_st && cfg_and && latch_a && hit_b && !arm_start |=> trig_pulse;
	endproperty
	a_and: assert property (p_and) else $error("latched AND did not trigger");

	property p_preload;
		arm_start && level_ok && !any_level
			|=> max_val == NEG_FULL_SCALE && min_val == POS_FULL_SCALE && !latch_a && !latch_b;
	endproperty
	a_preload: assert property (p_preload) else $error("preload wrong");

endmodule : trig_qualifier

// File: include/trig_qual_pkg.sv
// Purpose: Shared types and constants for the digitizer trigger qualifier.
// Assumes: 250 MHz sample clock, 16-bit signed samples, 8-bit threshold compare.
// Notes: Threshold levels arrive in sample counts and are rounded to 8 bits on arm.
package trig_qual_pkg;

	localparam int SAMPLE_W = 16;
	localparam int LEVEL_W = 8;
	localparam int LEVEL_IN_W = 19;
	localparam int LINE_W = 3;
	localparam int LINES = 8;
	localparam int PIN_W = 10;
	localparam int PIN_EXT = 9;
	localparam int PIN_GATE = 8;

	// Rounding of a count level down to the 8 compared bits
	localparam logic [LEVEL_IN_W-1:0] ROUND_BIAS = 19'h00080;
	localparam int LEVEL_LSB = 8;
	localparam int LEVEL_SIGN = 15;

	// Comparator preload values for full scale
	localparam logic [SAMPLE_W-1:0] NEG_FULL_SCALE = 16'h8000;
	localparam logic [SAMPLE_W-1:0] POS_FULL_SCALE = 16'h7FFF;
	localparam logic [LEVEL_W-1:0] LEVEL_PAD = 8'h00;

	// Output trigger strobe width
	localparam int CLK_MHZ = 250;
	localparam int STROBE_NS = 100;
	localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [LINES-1:0] LINE_ONE = 8'h01;
	localparam logic [LINES-1:0] LINES_OFF = 8'h00;

	typedef enum logic [3:0] {
		software_source_mode,
		command_source_mode,
		ext_rise_mode,
		ext_fall_mode,
		above_level_mode,
		below_level_mode,
		slope_rise_mode,
		slope_fall_mode,
		backplane_mode
	} trig_src_t;

	typedef enum logic [1:0] {idle_st, armed_st, collect_st} qual_state_t;

	// True for sources that look at the sample stream
	function automatic logic is_level(input trig_src_t s);
		is_level = (s == above_level_mode) || (s == below_level_mode) ||
			(s == slope_rise_mode) || (s == slope_fall_mode);
	endfunction : is_level

endpackage : trig_qual_pkg

// File: src/cond_detect.sv
// Purpose: One trigger condition detector for a selected source.
// Assumes: Pin levels arrive already synchronised, with their previous value.
// Notes: Slope hits are registered, so they fire one sample after the crossing.
`timescale 1ns/10ps
module cond_detect
	import trig_qual_pkg::*;
(
	input wire logic sys_clk, // Sample clock
	input wire logic rst_b, // Async reset, active low
	input wire trig_src_t src, // Selected source
	input wire logic enable, // Level and slope detection allowed
	input wire logic [LEVEL_W-1:0] level, // Rounded signed threshold
	input wire logic [LEVEL_W-1:0] sample_hi, // Top bits of current sample
	input wire logic [LEVEL_W-1:0] prev_hi, // Top bits of previous sample
	input wire logic cmd_hit, // Word-serial trigger command pulse
	input wire logic ext_now, // External pin, synchronised
	input wire logic ext_prev, // External pin, one cycle older
	input wire logic [LINES-1:0] bp_now, // Backplane lines, synchronised
	input wire logic [LINES-1:0] bp_prev, // Backplane lines, one cycle older
	input wire logic [LINE_W-1:0] bp_sel, // Backplane input line
	input wire logic bp_rising, // Backplane active edge is rising
	output logic hit // Condition satisfied this cycle
);

	logic slope_hit;
	logic next_slope_hit;
	logic above;
	logic below;
	logic bp_edge;

	// Signed compares on the eight top bits only
	assign above = $signed(sample_hi) > $signed(level);
	assign below = $signed(sample_hi) < $signed(level);
	assign bp_edge = bp_rising ? (bp_now[bp_sel] & ~bp_prev[bp_sel]) :
		(~bp_now[bp_sel] & bp_prev[bp_sel]);

	// Crossing detection in the programmed direction
	always_comb begin
		next_slope_hit = 1'b0;
		if (enable && src == slope_rise_mode) begin
			next_slope_hit = ($signed(prev_hi) <= $signed(level)) && above;
		end else if (enable && src == slope_fall_mode) begin
			next_slope_hit = ($signed(prev_hi) >= $signed(level)) && below;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			slope_hit <= 1'b0;
		end else begin
			slope_hit <= next_slope_hit;
		end
	end

	// Source selection
	always_comb begin
		case (src)
			software_source_mode: hit = 1'b1;
			command_source_mode: hit = cmd_hit;
			ext_rise_mode: hit = ext_now & ~ext_prev;
			ext_fall_mode: hit = ~ext_now & ext_prev;
			above_level_mode: hit = enable & above;
			below_level_mode: hit = enable & below;
			slope_rise_mode: hit = slope_hit;
			slope_fall_mode: hit = slope_hit;
			backplane_mode: hit = bp_edge;
			default: hit = 1'b0;
		endcase
	end

endmodule : cond_detect

// File: src/peak_track.sv
// Purpose: Running maximum and minimum comparators.
// Assumes: Samples are signed and arrive one per clock.
// Notes: A load wins over an update in the same cycle.
`timescale 1ns/10ps
module peak_track
	import trig_qual_pkg::*;
(
	input wire logic sys_clk, // Sample clock
	input wire logic rst_b, // Async reset, active low
	input wire logic load, // Preload both comparators
	input wire logic [SAMPLE_W-1:0] load_max, // Preload for the maximum
	input wire logic [SAMPLE_W-1:0] load_min, // Preload for the minimum
	input wire logic update, // Tracking allowed this cycle
	input wire logic [SAMPLE_W-1:0] sample, // Current sample
	output logic [SAMPLE_W-1:0] max_val, // Largest sample seen
	output logic [SAMPLE_W-1:0] min_val // Smallest sample seen
);

	logic [SAMPLE_W-1:0] next_max;
	logic [SAMPLE_W-1:0] next_min;

	// Preload, then raise the maximum and lower the minimum
	always_comb begin
		next_max = max_val;
		next_min = min_val;
		if (load) begin
			next_max = load_max;
			next_min = load_min;
		end else if (update) begin
			if ($signed(sample) > $signed(max_val)) begin
				next_max = sample;
			end
			if ($signed(sample) < $signed(min_val)) begin
				next_min = sample;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			max_val <= NEG_FULL_SCALE;
			min_val <= POS_FULL_SCALE;
		end else begin
			max_val <= next_max;
			min_val <= next_min;
		end
	end

endmodule : peak_track

// File: tb/trig_lines_model.sv
// Purpose: Far side of the trigger pins: external pin, gate pin, backplane lines.
// Assumes: Backplane lines are open-collector with pull-ups.
// Notes: Other boards pull lines low through pull_mask; the block's strobe joins in.
`timescale 1ns/10ps
module trig_lines_model (
	input wire logic ext_level, // Level put on the external pin
	input wire logic gate_level, // Level put on the gate pin
	input wire logic [7:0] pull_mask, // Lines held low by other boards
	input wire logic [7:0] bp_ttl_o, // Block drive value
	input wire logic [7:0] bp_ttl_oe, // Block drive enable
	output logic ext_trig_pin, // External trigger pin
	output logic ext_gate_pin, // External gate pin
	output logic [7:0] bp_ttl_in // Resolved backplane lines
);
	// Pins follow the far-side levels directly
	assign ext_trig_pin = ext_level;
	assign ext_gate_pin = gate_level;
	// Wired-AND with pull-up: any enabled low driver wins
	assign bp_ttl_in = ~(pull_mask | (bp_ttl_oe & ~bp_ttl_o));
endmodule : trig_lines_model

// File: tb/digitizer_trigger_qualifier_tb.sv
// Purpose: Self-checking bench for the trigger qualifier.
// Assumes: Far-side pins come from trig_lines_model.
// Notes: Counts in n are clock steps after a drive, each step 1 ns past the edge.
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module digitizer_trigger_qualifier_tb
	import trig_qual_pkg::*;
;
	logic sys_clk, rst_b, arm_start, cmd_trig, use_b, and_mode, bp_rising, out_en;
	logic record_mode, readout_req, ext_trig_pin, ext_gate_pin, ext_level, gate_level;
	logic collecting, trig_pulse, arm_error, readout_valid;
	trig_src_t src_a, src_b;
	logic [LEVEL_IN_W-1:0] level_a, level_b;
	logic [LINE_W-1:0] backplane_input_line_select, out_line;
	logic [SAMPLE_W-1:0] sample, max_val, min_val, readout_max, readout_min;
	logic [LINES-1:0] bp_ttl_in, bp_ttl_o, bp_ttl_oe, pull_mask;
	int num_errors = 0;
	int checked = 0;
	int n;
	trig_qualifier i_dut (.*);
	trig_lines_model i_far (.*);
	// 250 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	// Helpers: step past edges, drive stimulus, wait for a trigger
	task automatic step(input int k = 1);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic drive(input logic [15:0] s, input logic e, input logic [7:0] p);
		@(posedge sys_clk);
		sample <= s;
		ext_level <= e;
		pull_mask <= p;
		#1;
	endtask : drive
	task automatic wait_trig(input int lim);
		n = 0;
		while (n < lim && trig_pulse !== 1'b1) begin
			step();
			n++;
		end
	endtask : wait_trig
	task automatic arm(input trig_src_t a, input trig_src_t b, input logic ub,
		input logic am, input logic [18:0] la, input logic [18:0] lb);
		@(posedge sys_clk);
		src_a <= a;
		src_b <= b;
		{use_b, and_mode, level_a, level_b} <= {ub, am, la, lb};
		arm_start <= 1'b1;
		@(posedge sys_clk);
		arm_start <= 1'b0;
		#1;
	endtask : arm
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// Scenarios
	task automatic t_soft();
		arm(software_source_mode, software_source_mode, 1'b0, 1'b0, '0, '0);
		`CHK({max_val, min_val}, 32'h80007FFF)
		wait_trig(4);
		`CHK(n, 1)
		`CHK({collecting, bp_ttl_oe, bp_ttl_o}, 17'h18000)
		step(24);
		`CHK(bp_ttl_oe, 8'h80)
		step();
		`CHK(bp_ttl_oe, 8'h00)
		$display("test software done");
	endtask : t_soft
	task automatic t_peak();
		drive(16'h1234, 1'b0, 8'h00);
		drive(16'hF000, 1'b0, 8'h00);
		step();
		`CHK({max_val, min_val}, 32'h1234F000)
		@(posedge sys_clk);
		gate_level <= 1'b1;
		step(3);
		drive(16'h7000, 1'b0, 8'h00);
		step(2);
		`CHK(max_val, 16'h1234)
		@(posedge sys_clk);
		gate_level <= 1'b0;
		record_mode <= 1'b1;
		step(4);
		`CHK(max_val, 16'h1234)
		@(posedge sys_clk);
		record_mode <= 1'b0;
		step();
		`CHK(max_val, 16'h7000)
		@(posedge sys_clk);
		readout_req <= 1'b1;
		@(posedge sys_clk);
		readout_req <= 1'b0;
		#1;
		`CHK({readout_valid, readout_max, readout_min}, 33'h1_7000_F000)
		$display("test peaks done");
	endtask : t_peak
	task automatic t_cmd();
		arm(command_source_mode, command_source_mode, 1'b0, 1'b0, '0, '0);
		wait_trig(8);
		`CHK(n, 8)
		@(posedge sys_clk);
		cmd_trig <= 1'b1;
		@(posedge sys_clk);
		cmd_trig <= 1'b0;
		#1;
		wait_trig(3);
		`CHK(n, 0)
		$display("test command done");
	endtask : t_cmd
	// Pin already high at arm must fall and rise again
	task automatic t_ext();
		drive(16'h0000, 1'b1, 8'h00);
		step(3);
		arm(ext_rise_mode, ext_rise_mode, 1'b0, 1'b0, '0, '0);
		wait_trig(6);
		`CHK(n, 6)
		drive(16'h0000, 1'b0, 8'h00);
		wait_trig(6);
		`CHK(n, 6)
		drive(16'h0000, 1'b1, 8'h00);
		wait_trig(5);
		`CHK(n, 3)
		$display("test edge done");
	endtask : t_ext
	// One source: quiet stimulus first, then the firing one
	task automatic t_src(input trig_src_t m, input logic [18:0] lv, input logic [31:0] pre,
		input logic [15:0] qs, input logic [7:0] qp, input logic [15:0] fs,
		input logic [7:0] fp, input int nx);
		drive(qs, 1'b0, qp);
		arm(m, m, 1'b0, 1'b0, lv, lv);
		`CHK({max_val, min_val}, pre)
		wait_trig(6);
		`CHK(n, 6)
		drive(fs, 1'b0, fp);
		wait_trig(5);
		`CHK(n, nx)
		$display("test source %0d done", m);
	endtask : t_src
	task automatic t_range();
		arm(above_level_mode, above_level_mode, 1'b0, 1'b0, 19'h08000, '0);
		`CHK(arm_error, 1'b1)
		drive(16'h7F00, 1'b0, 8'h00);
		wait_trig(8);
		`CHK(n, 8)
		arm(software_source_mode, software_source_mode, 1'b0, 1'b0, '0, '0);
		`CHK(arm_error, 1'b0)
		$display("test range done");
	endtask : t_range
	// Level side waits for the edge side under AND, not under OR
	task automatic t_and();
		drive(16'h4000, 1'b0, 8'h00);
		arm(ext_rise_mode, above_level_mode, 1'b1, 1'b1, '0, '0);
		wait_trig(8);
		`CHK(n, 8)
		drive(16'h4000, 1'b1, 8'h00);
		wait_trig(8);
		`CHK(n < 8, 1'b1)
		drive(16'h4000, 1'b0, 8'h00);
		arm(ext_rise_mode, above_level_mode, 1'b1, 1'b0, '0, '0);
		wait_trig(4);
		`CHK(n < 4, 1'b1)
		$display("test combine done");
	endtask : t_and
	// Reset, then run every scenario in turn
	initial begin
		{rst_b, arm_start, cmd_trig, use_b, and_mode, bp_rising, record_mode, readout_req} = '0;
		{ext_level, gate_level, pull_mask, sample, level_a, level_b} = '0;
		src_a = software_source_mode;
		src_b = software_source_mode;
		out_en = 1'b1;
		out_line = 3'h7;
		backplane_input_line_select = 3'h5;
		repeat (20) @(posedge sys_clk);
		`CHK({max_val, min_val, collecting, arm_error, bp_ttl_oe}, 42'h2_0001_FFFC_00)
		rst_b <= 1'b1;
		t_soft();
		t_peak();
		t_cmd();
		t_ext();
		t_src(above_level_mode, 19'h004C0, 32'h05000500, 16'h0500, 8'h00, 16'h0600, 8'h00, 1);
		t_src(below_level_mode, 19'h7FB00, 32'hFB00FB00, 16'hFB00, 8'h00, 16'hFA00, 8'h00, 1);
		t_src(slope_rise_mode, 19'h00000, 32'h00000000, 16'hFF00, 8'h00, 16'h0100, 8'h00, 2);
		t_src(backplane_mode, 19'h00000, 32'h80007FFF, 16'h0000, 8'h10, 16'h0000, 8'h30, 3);
		t_range();
		t_and();
		tally_and_finish();
	end
	// Watchdog well beyond the expected run of about 0.73 us
	initial begin
		#5000;
		num_errors++;
		tally_and_finish();
	end
endmodule : digitizer_trigger_qualifier_tb
